// ---- fcl_defs.svh ----
`ifndef FCL_DEFS_SVH
`define FCL_DEFS_SVH

// core clock and strap window timing
`define FCL_CLK_KHZ 125000
`define FCL_STRAP_TIME_US 2000
`define FCL_STRAP_CYCLES ((`FCL_STRAP_TIME_US * `FCL_CLK_KHZ) / 1000)

// fixed output frequencies in kHz
`define FCL_REF_KHZ 14318
`define FCL_USB_KHZ 48000
`define FCL_USB_HALF_KHZ 24000

// pin-selected processor and bus frequencies in kHz
`define FCL_PROC_SEL3_KHZ 133300
`define FCL_PROC_SEL2_KHZ 105000
`define FCL_PROC_SEL1_KHZ 100000
`define FCL_PROC_SEL0_KHZ 66800
`define FCL_BUS_SEL2_KHZ 35000
`define FCL_BUS_STD_KHZ 33300

// serial frequency table
`define FCL_TABLE_DEPTH 32
`define FCL_SEL_W 5
`define FCL_MAX_KHZ 155000
`define FCL_RAMP_BASE_KHZ 100000
`define FCL_RAMP_STEP_KHZ 2000
`define FCL_RAMP_FIRST 4
`define FCL_BUS_SHIFT 2

// waveform synthesis
`define FCL_PHASE_W 32
`define FCL_KHZ_W 18
`define FCL_NCO_CHANNELS 5
`define FCL_BUS_COPIES 7

`endif

// ---- fcl_pkg.sv ----
`include "fcl_defs.svh"

package fcl_pkg;

  typedef logic [`FCL_KHZ_W-1:0] fcl_khz_t;
  typedef logic [`FCL_PHASE_W-1:0] fcl_phase_t;
  typedef logic [`FCL_SEL_W-1:0] fcl_sel_t;

  typedef struct packed {
    fcl_khz_t procKhz;
    fcl_khz_t busKhz;
    fcl_phase_t busInc;
  } fcl_entry_t;

  typedef struct packed {
    fcl_sel_t sel;
    logic fromSerial;
    fcl_khz_t procKhz;
    fcl_khz_t busKhz;
  } fcl_pll_cfg_t;

  typedef struct packed {
    logic valid;
    logic override;
    fcl_sel_t sel;
  } fcl_serial_cmd_t;

  typedef enum logic [0:0] {
    FCL_SAMPLE,
    FCL_RUN
  } fcl_state_t;

  // phase step per core clock for a wave of the given frequency
  function automatic fcl_phase_t fcl_inc(input fcl_khz_t khz);
    logic [63:0] wide;
    wide = ({46'h0, khz} << `FCL_PHASE_W) / 64'(`FCL_CLK_KHZ);
    return wide[`FCL_PHASE_W-1:0];
  endfunction

endpackage

// ---- fcl_freq_rom.sv ----
`timescale 1ns/1ps
`include "fcl_defs.svh"

module fcl_freq_rom
  import fcl_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // lookup
  input wire fcl_sel_t addr,
  output fcl_entry_t rdData
);

  function automatic fcl_entry_t entryOf(input int idx);
    fcl_entry_t e;
    int proc;
    int bus;
    proc = `FCL_RAMP_BASE_KHZ + (idx - `FCL_RAMP_FIRST) * `FCL_RAMP_STEP_KHZ;
    bus = proc >> `FCL_BUS_SHIFT;
    case (idx)
      0: begin
        proc = `FCL_PROC_SEL0_KHZ;
        bus = `FCL_BUS_STD_KHZ;
      end
      1: begin
        proc = `FCL_PROC_SEL1_KHZ;
        bus = `FCL_BUS_STD_KHZ;
      end
      2: begin
        proc = `FCL_PROC_SEL2_KHZ;
        bus = `FCL_BUS_SEL2_KHZ;
      end
      3: begin
        proc = `FCL_PROC_SEL3_KHZ;
        bus = `FCL_BUS_STD_KHZ;
      end
      `FCL_TABLE_DEPTH - 1: begin
        proc = `FCL_MAX_KHZ;
        bus = `FCL_MAX_KHZ >> `FCL_BUS_SHIFT;
      end
      default: begin
      end
    endcase
    e.procKhz = `FCL_KHZ_W'(proc);
    e.busKhz = `FCL_KHZ_W'(bus);
    e.busInc = fcl_inc(`FCL_KHZ_W'(bus));
    return e;
  endfunction

  fcl_entry_t romTable [`FCL_TABLE_DEPTH];

  genvar g;
  generate
    for (g = 0; g < `FCL_TABLE_DEPTH; g++) begin : gEntry
      assign romTable[g] = entryOf(g);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData <= '0;
    end else if (ce) begin
      rdData <= romTable[addr];
    end
  end

endmodule

// ---- fcl_clock_select.sv ----
`timescale 1ns/1ps
`include "fcl_defs.svh"

module fcl_clock_select
  import fcl_pkg::*;
#(
  parameter logic [`FCL_KHZ_W-1:0] STRAP_CYCLES = `FCL_KHZ_W'(`FCL_STRAP_CYCLES)
) (
  // clock, power-on reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // select pin and serial settings
  input wire logic freqSelectLow,
  input wire fcl_serial_cmd_t serialCmd,
  // usb-rate pin, doubles as high select strap
  input wire logic usbRatePinIn,
  output logic usbRateOut,
  output logic usbRateOeN,
  // doubled-reference pin, doubles as usb-rate strap
  input wire logic refPinIn,
  output logic doubledReferenceOut,
  output logic doubledReferenceOeN,
  // clock outputs
  output fcl_pll_cfg_t processorClockCfg,
  output logic [`FCL_BUS_COPIES-1:0] busClockOut,
  output logic interruptCtrlClockOut,
  output logic usbClockOut,
  output logic strapsLatched
);

  localparam fcl_phase_t INC_REF = fcl_inc(`FCL_KHZ_W'(`FCL_REF_KHZ));
  localparam fcl_phase_t INC_USB = fcl_inc(`FCL_KHZ_W'(`FCL_USB_KHZ));
  localparam fcl_phase_t INC_USB_HALF = fcl_inc(`FCL_KHZ_W'(`FCL_USB_HALF_KHZ));
  localparam logic [`FCL_KHZ_W-1:0] KHZ_SEL3 = `FCL_KHZ_W'(`FCL_PROC_SEL3_KHZ);
  localparam logic [`FCL_KHZ_W-1:0] KHZ_SEL2 = `FCL_KHZ_W'(`FCL_PROC_SEL2_KHZ);
  localparam logic [`FCL_KHZ_W-1:0] KHZ_SEL1 = `FCL_KHZ_W'(`FCL_PROC_SEL1_KHZ);
  localparam logic [`FCL_KHZ_W-1:0] KHZ_SEL0 = `FCL_KHZ_W'(`FCL_PROC_SEL0_KHZ);
  localparam logic [`FCL_KHZ_W-1:0] KHZ_BUS2 = `FCL_KHZ_W'(`FCL_BUS_SEL2_KHZ);
  localparam logic [`FCL_KHZ_W-1:0] KHZ_BUS_STD = `FCL_KHZ_W'(`FCL_BUS_STD_KHZ);
  localparam logic [`FCL_KHZ_W-1:0] KHZ_MAX = `FCL_KHZ_W'(`FCL_MAX_KHZ);

  // pins: two-stage synchronisers, stage one read only by stage two
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  wire logic [2:0] pinRaw = {freqSelectLow, usbRatePinIn, refPinIn};
  wire logic fsLowSync = pinSync[2];
  wire logic usbPinSync = pinSync[1];
  wire logic refPinSync = pinSync[0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else if (ce) begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // strap window
  fcl_state_t state;
  fcl_state_t next_state;
  logic [`FCL_KHZ_W-1:0] timer;
  logic freqSelectHigh;
  logic usbRateStrapN;
  wire logic timerDone = (timer == STRAP_CYCLES - `FCL_KHZ_W'(1));
  wire logic [`FCL_KHZ_W-1:0] next_timer = timerDone ? timer : timer + `FCL_KHZ_W'(1);
  wire logic latchNow = (state == FCL_SAMPLE) && timerDone;
  wire logic running = (state == FCL_RUN);

  always_comb begin
    next_state = state;
    case (state)
      FCL_SAMPLE: begin
        if (timerDone) begin
          next_state = FCL_RUN;
        end
      end
      FCL_RUN: next_state = FCL_RUN;
      default: next_state = FCL_SAMPLE;
    endcase
  end

  // timer starts at reset release and parks at terminal count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= FCL_SAMPLE;
      timer <= '0;
    end else if (ce) begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // straps captured once; only power-on reset clears them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freqSelectHigh <= 1'b0;
      usbRateStrapN <= 1'b0;
      strapsLatched <= 1'b0;
    end else if (ce && latchNow) begin
      freqSelectHigh <= usbPinSync;
      usbRateStrapN <= refPinSync;
      strapsLatched <= 1'b1;
    end
  end

  // pins float until the straps are in, so the resistors set the level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      usbRateOeN <= 1'b1;
      doubledReferenceOeN <= 1'b1;
    end else if (ce && latchNow) begin
      usbRateOeN <= 1'b0;
      doubledReferenceOeN <= 1'b0;
    end
  end

  // serial override stays until a command releases it
  logic overrideEn;
  fcl_sel_t overrideSel;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      overrideEn <= 1'b0;
      overrideSel <= '0;
    end else if (ce && serialCmd.valid) begin
      overrideEn <= serialCmd.override;
      overrideSel <= serialCmd.sel;
    end
  end

  wire logic [1:0] pinCode = {freqSelectHigh, fsLowSync};
  wire fcl_sel_t selIdx = overrideEn ? overrideSel : {3'h0, pinCode};

  fcl_entry_t romWord;
  fcl_sel_t selIdxQ;
  logic overrideQ;
  // the word read on the latch edge still holds the pre-strap select,
  // so loads wait one cycle rather than hand the pll a wrong setting
  logic cfgLive;

  fcl_freq_rom uRom (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .addr(selIdx),
    .rdData(romWord)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      selIdxQ <= '0;
      overrideQ <= 1'b0;
      cfgLive <= 1'b0;
    end else if (ce) begin
      selIdxQ <= selIdx;
      overrideQ <= overrideEn;
      cfgLive <= running;
    end
  end

  // processor setting held at zero until the high select strap is known
  fcl_phase_t busInc;
  wire logic busRestart = cfgLive && (romWord.busInc != busInc);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      processorClockCfg <= '0;
      busInc <= '0;
    end else if (ce && cfgLive) begin
      processorClockCfg.sel <= selIdxQ;
      processorClockCfg.fromSerial <= overrideQ;
      processorClockCfg.procKhz <= romWord.procKhz;
      processorClockCfg.busKhz <= romWord.busKhz;
      busInc <= romWord.busInc;
    end
  end

  // waveform channels: bus, interrupt ctrl, usb, usb-rate, doubled ref
  // edges jitter by one core period since the phase step is not integral
  fcl_phase_t chanInc [`FCL_NCO_CHANNELS];
  fcl_phase_t phaseOf [`FCL_NCO_CHANNELS];
  logic [`FCL_NCO_CHANNELS-1:0] waveBit;

  assign chanInc[0] = busInc;
  assign chanInc[1] = INC_REF;
  assign chanInc[2] = INC_USB;
  assign chanInc[3] = !running ? '0 : (usbRateStrapN ? INC_USB_HALF : INC_USB);
  assign chanInc[4] = running ? INC_REF : '0;

  genvar g;
  generate
    for (g = 0; g < `FCL_NCO_CHANNELS; g++) begin : gNco
      fcl_phase_t acc;
      wire logic restart = (g == 0) && busRestart;
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          acc <= '0;
        end else if (ce) begin
          acc <= restart ? '0 : acc + chanInc[g];
        end
      end
      assign phaseOf[g] = acc;
      assign waveBit[g] = acc[`FCL_PHASE_W-1];
    end
  endgenerate

  assign busClockOut = {`FCL_BUS_COPIES{waveBit[0]}};
  assign interruptCtrlClockOut = waveBit[1];
  assign usbClockOut = waveBit[2];
  assign usbRateOut = waveBit[3];
  assign doubledReferenceOut = waveBit[4];

  chk_strap_float: assert property (@(posedge clk) disable iff (!rst_b)
    state == FCL_SAMPLE |-> usbRateOeN && doubledReferenceOeN)
    else $error("dual pin driven during strap window");

  chk_window_end: assert property (@(posedge clk) disable iff (!rst_b)
    ce && latchNow |=> running && !usbRateOeN && !doubledReferenceOeN && strapsLatched)
    else $error("strap window did not close on terminal count");

  chk_window_length: assert property (@(posedge clk) disable iff (!rst_b)
    running |-> timer == STRAP_CYCLES - `FCL_KHZ_W'(1))
    else $error("left strap window before terminal count");

  chk_straps_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    running && $past(running) |-> $stable(freqSelectHigh) && $stable(usbRateStrapN))
    else $error("latched strap changed after window");

  chk_strap_capture: assert property (@(posedge clk) disable iff (!rst_b)
    ce && latchNow |=> usbRateStrapN == $past(refPinSync) && freqSelectHigh == $past(usbPinSync))
    else $error("strap latch took wrong level");

  chk_rate_pick: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b && running |=>
    phaseOf[3] == $past(phaseOf[3]) + (usbRateStrapN ? INC_USB_HALF : INC_USB))
    else $error("usb-rate pin at wrong frequency");

  chk_pin_top: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && running && !overrideEn && pinCode == 2'h3) [*3] |->
    processorClockCfg.procKhz == KHZ_SEL3 && !processorClockCfg.fromSerial)
    else $error("select 11 not decoded");

  chk_pin_mid: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && running && !overrideEn && pinCode == 2'h2) [*3] |->
    processorClockCfg.procKhz == KHZ_SEL2 && processorClockCfg.busKhz == KHZ_BUS2)
    else $error("select 10 not decoded");

  chk_pin_low: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && running && !overrideEn && pinCode == 2'h0) [*3] |->
    processorClockCfg.procKhz == KHZ_SEL0)
    else $error("select 00 not decoded");

  chk_serial_max: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && running && overrideEn && overrideSel == 5'h1F) [*3] |->
    processorClockCfg.procKhz == KHZ_MAX && processorClockCfg.fromSerial)
    else $error("serial top setting not applied");

  chk_bus_restart: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(busInc) |-> phaseOf[0] == '0)
    else $error("bus clocks not restarted with processor change");

  // steps are only checked from an edge that was itself out of reset
  chk_int_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> phaseOf[1] == $past(phaseOf[1]) + INC_REF)
    else $error("interrupt clock step wrong");

  chk_usb_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> phaseOf[2] == $past(phaseOf[2]) + INC_USB)
    else $error("usb clock step wrong");

  chk_ref_step: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b && running |=> phaseOf[4] == $past(phaseOf[4]) + INC_REF)
    else $error("doubled reference step wrong");

  chk_pins_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !running |-> !usbRateOut && !doubledReferenceOut)
    else $error("dual pin toggled during strap window");

  chk_cfg_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !running |-> processorClockCfg == '0 && busClockOut == '0)
    else $error("pll setting given before straps");

  chk_pin_one: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && running && !overrideEn && pinCode == 2'h1) [*3] |->
    processorClockCfg.procKhz == KHZ_SEL1 && processorClockCfg.busKhz == KHZ_BUS_STD)
    else $error("select 01 not decoded");

  chk_serial_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && running && overrideEn) [*3] |->
    processorClockCfg.sel == $past(overrideSel, 2) && processorClockCfg.fromSerial)
    else $error("serial setting not applied");

endmodule

// ---- fcl_board_model.sv ----
`timescale 1ns/1ps
module fcl_board_model (
  // strap resistor levels
  input wire logic strap14,
  input wire logic strap27,
  // device pin buffers
  input wire logic out14,
  input wire logic oeN14,
  input wire logic out27,
  input wire logic oeN27,
  // resolved pin levels
  output logic pin14,
  output logic pin27
);
  // a released pin settles to its 10k strap, a driven one follows the buffer
  assign pin14 = oeN14 ? strap14 : out14;
  assign pin27 = oeN27 ? strap27 : out27;
endmodule

// ---- tb_clock_select_strap_logic.sv ----
`timescale 1ns/1ps
`include "fcl_defs.svh"
module tb_clock_select_strap_logic import fcl_pkg::*; ();
  localparam int STRAP = 20;
  localparam int WIN = 1000;
  logic clk, rst_b, ce, freqSelectLow;
  fcl_serial_cmd_t serialCmd;
  logic s14, s27, p14, p27, usbRateOut, usbRateOeN, doubledReferenceOut, doubledReferenceOeN;
  logic interruptCtrlClockOut, usbClockOut, strapsLatched;
  logic [`FCL_BUS_COPIES-1:0] busClockOut;
  wire logic [4:0] waves = {usbRateOut, doubledReferenceOut, interruptCtrlClockOut, usbClockOut,
    busClockOut[0]};
  fcl_pll_cfg_t processorClockCfg, prevCfg;
  fcl_pll_cfg_t expQ[$];
  int n_mismatch = 0;
  int checks = 0;

  fcl_clock_select #(.STRAP_CYCLES(18'(STRAP))) DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
    .freqSelectLow(freqSelectLow), .serialCmd(serialCmd), .usbRatePinIn(p14),
    .usbRateOut(usbRateOut), .usbRateOeN(usbRateOeN), .refPinIn(p27),
    .doubledReferenceOut(doubledReferenceOut), .doubledReferenceOeN(doubledReferenceOeN),
    .processorClockCfg(processorClockCfg), .busClockOut(busClockOut),
    .interruptCtrlClockOut(interruptCtrlClockOut), .usbClockOut(usbClockOut),
    .strapsLatched(strapsLatched));

  fcl_board_model board (.strap14(s14), .strap27(s27), .out14(usbRateOut),
    .oeN14(usbRateOeN), .out27(doubledReferenceOut), .oeN27(doubledReferenceOeN),
    .pin14(p14), .pin27(p27));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic fail(string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic cmpVec(logic [4:0] got, logic [4:0] exp, string m);
    checks++;
    if (got !== exp) fail(m);
  endtask

  // edge counts jitter by one clk, so a count of one off is accepted
  task automatic cmpCount(int got, int khz, string m);
    int exp;
    exp = khz * WIN / `FCL_CLK_KHZ;
    checks++;
    if (got < exp - 1 || got > exp + 1) fail(m);
  endtask

  task automatic cmpCfg(fcl_pll_cfg_t got);
    checks++;
    if (expQ.size() == 0) fail("unexpected pll setting");
    else if (got !== expQ.pop_front()) fail("wrong pll setting");
  endtask

  function automatic fcl_pll_cfg_t pinCfg(logic [1:0] c);
    int p;
    p = c == 2'h3 ? 133300 : c == 2'h2 ? 105000 : c == 2'h1 ? 100000 : 66800;
    return '{sel: 5'(c), fromSerial: 1'b0, procKhz: 18'(p),
      busKhz: 18'(c == 2'h2 ? 35000 : 33300)};
  endfunction

  function automatic fcl_pll_cfg_t serCfg(int i);
    int p;
    p = i == 31 ? 155000 : 100000 + (i - 4) * 2000;
    return '{sel: 5'(i), fromSerial: 1'b1, procKhz: 18'(p), busKhz: 18'(p / 4)};
  endfunction

  // watches every change of the pll setting outside reset
  initial begin
    prevCfg = '0;
    forever begin
      @(posedge clk);
      #1;
      if (rst_b === 1'b1 && processorClockCfg !== prevCfg) cmpCfg(processorClockCfg);
      prevCfg = processorClockCfg;
    end
  end

  task automatic rates(int kRate, int kBus);
    int cnt[5];
    logic [4:0] prv, cur;
    cnt = '{default: 0};
    // start from the live level so a high wave is not counted as an edge
    prv = waves;
    repeat (WIN) begin
      @(posedge clk);
      #1;
      cur = {usbRateOut, doubledReferenceOut, interruptCtrlClockOut, usbClockOut, busClockOut[0]};
      for (int k = 0; k < 5; k++) cnt[k] += int'(cur[k] & ~prv[k]);
      prv = cur;
      if (busClockOut !== {`FCL_BUS_COPIES{busClockOut[0]}}) fail("bus copies differ");
    end
    cmpCount(cnt[4], kRate, "usb-rate pin rate");
    cmpCount(cnt[3], 14318, "doubled reference rate");
    cmpCount(cnt[2], 14318, "interrupt clock rate");
    cmpCount(cnt[1], 48000, "usb clock rate");
    cmpCount(cnt[0], kBus, "bus clock rate");
  endtask

  task automatic powerUp(logic v14, logic v27, logic f);
    int n;
    s14 <= v14;
    s27 <= v27;
    freqSelectLow <= f;
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (n = 1; n <= 100; n++) begin
      @(posedge clk);
      #1;
      if (strapsLatched === 1'b1) break;
      cmpVec({usbRateOeN, doubledReferenceOeN, usbRateOut, doubledReferenceOut, |busClockOut},
        5'h18, "pins driven in window");
    end
    cmpVec(5'(n == STRAP), 5'h01, "strap latch edge");
    cmpVec({3'h0, usbRateOeN, doubledReferenceOeN}, 5'h00, "pins not driven");
    expQ.push_back(pinCfg({v14, f}));
    rates(v27 ? 24000 : 48000, 33300);
  endtask

  task automatic send(logic o, int s);
    serialCmd <= '{valid: 1'b1, override: o, sel: 5'(s)};
    @(posedge clk);
    serialCmd <= '0;
    repeat (8) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fail("timeout");
    complete_run();
  end

  initial begin
    int idx;
    logic [4:0] snap;
    rst_b = 1'b0;
    ce = 1'b1;
    freqSelectLow = 1'b0;
    serialCmd = '0;
    s14 = 1'b0;
    s27 = 1'b0;
    void'($urandom(22));
    powerUp(1'b1, 1'b0, 1'b1);
    // pin 14 now toggles as a clock, the decode must keep its latched level
    expQ.push_back(pinCfg(2'h2));
    freqSelectLow <= 1'b0;
    repeat (8) @(posedge clk);
    rates(48000, 35000);
    idx = 4 + int'($urandom % 27);
    expQ.push_back(serCfg(idx));
    send(1'b1, idx);
    expQ.push_back(serCfg(31));
    send(1'b1, 31);
    expQ.push_back(pinCfg(2'h2));
    send(1'b0, 0);
    // with ce low every flop must hold, so no wave may move
    ce <= 1'b0;
    @(posedge clk);
    #1;
    snap = waves;
    repeat (5) begin
      @(posedge clk);
      #1;
      cmpVec(waves, snap, "wave moved with ce low");
    end
    ce <= 1'b1;
    powerUp(1'b0, 1'b1, 1'b0);
    expQ.push_back(pinCfg(2'h1));
    freqSelectLow <= 1'b1;
    repeat (8) @(posedge clk);
    cmpVec(5'(expQ.size()), 5'h00, "settings missing");
    complete_run();
  end
endmodule
